// [common/exc_pkg.sv]
// Shared constants, slot map and decode functions for the exception state block
package exc_pkg;
    localparam int NUM_SLOT = 16;
    localparam int NUM_IRQ = 7;
    localparam int SLOT_W = 4;
    localparam int CFG_PRIO_W = 3;
    localparam int CFG_W = NUM_SLOT * CFG_PRIO_W;
    localparam int PRIO_W = 5;

    // Slot map: banked exceptions take one slot per security state
    localparam logic [SLOT_W-1:0] SLOT_NMI = 4'h0;
    localparam logic [SLOT_W-1:0] SLOT_HF_S = 4'h1;
    localparam logic [SLOT_W-1:0] SLOT_HF_NS = 4'h2;
    localparam logic [SLOT_W-1:0] SLOT_MM_S = 4'h3;
    localparam logic [SLOT_W-1:0] SLOT_MM_NS = 4'h4;
    localparam logic [SLOT_W-1:0] SLOT_BF = 4'h5;
    localparam logic [SLOT_W-1:0] SLOT_UF_S = 4'h6;
    localparam logic [SLOT_W-1:0] SLOT_UF_NS = 4'h7;
    localparam logic [SLOT_W-1:0] SLOT_SF = 4'h8;
    localparam logic [SLOT_W-1:0] SLOT_IRQ0 = 4'h9;

    // Slots that can never be disabled by software
    localparam logic [NUM_SLOT-1:0] FIXED_EN_MASK = 16'h0007;

    // Fixed priorities, two's complement in five bits
    localparam logic signed [PRIO_W-1:0] PRIO_HF_SEC_TOP = 5'sh1d;
    localparam logic signed [PRIO_W-1:0] PRIO_NMI = 5'sh1e;
    localparam logic signed [PRIO_W-1:0] PRIO_HF = 5'sh1f;
    localparam logic signed [PRIO_W-1:0] PRIO_THREAD = 5'sh08;

    // Vector table byte offsets
    localparam logic [31:0] VEC_RESET = 32'h00000004;
    localparam logic [31:0] VEC_NMI = 32'h00000008;
    localparam logic [31:0] VEC_HF = 32'h0000000c;
    localparam logic [31:0] VEC_MM = 32'h00000010;
    localparam logic [31:0] VEC_BF = 32'h00000014;
    localparam logic [31:0] VEC_UF = 32'h00000018;
    localparam logic [31:0] VEC_SF = 32'h0000001c;
    localparam logic [31:0] VEC_IRQ_BASE = 32'h00000040;

    // Priority of a slot; configurable slots read their three-bit field
    function automatic logic signed [PRIO_W-1:0] slot_prio(
        input logic [SLOT_W-1:0] s,
        input logic route,
        input logic [CFG_W-1:0] cfg
    );
        logic [CFG_PRIO_W-1:0] field;
        field = cfg[CFG_PRIO_W*s +: CFG_PRIO_W];
        case (s)
            SLOT_NMI: slot_prio = PRIO_NMI;
            SLOT_HF_S: slot_prio = route ? PRIO_HF_SEC_TOP : PRIO_HF;
            SLOT_HF_NS: slot_prio = PRIO_HF;
            default: slot_prio = $signed({2'h0, field});
        endcase
    endfunction

    // Security state that a slot's handler runs in
    function automatic logic slot_secure(
        input logic [SLOT_W-1:0] s,
        input logic route,
        input logic [NUM_IRQ-1:0] irq_ns
    );
        logic [SLOT_W-1:0] irq_idx;
        irq_idx = s - SLOT_IRQ0;
        case (s)
            SLOT_NMI, SLOT_BF: slot_secure = ~route;
            SLOT_HF_S, SLOT_MM_S, SLOT_UF_S, SLOT_SF: slot_secure = 1'b1;
            SLOT_HF_NS, SLOT_MM_NS, SLOT_UF_NS: slot_secure = 1'b0;
            default: slot_secure = ~irq_ns[irq_idx[2:0]];
        endcase
    endfunction

    // Handler vector address of a slot
    function automatic logic [31:0] vector_of(input logic [SLOT_W-1:0] s);
        logic [SLOT_W-1:0] irq_idx;
        irq_idx = s - SLOT_IRQ0;
        case (s)
            SLOT_NMI: vector_of = VEC_NMI;
            SLOT_HF_S, SLOT_HF_NS: vector_of = VEC_HF;
            SLOT_MM_S, SLOT_MM_NS: vector_of = VEC_MM;
            SLOT_BF: vector_of = VEC_BF;
            SLOT_UF_S, SLOT_UF_NS: vector_of = VEC_UF;
            SLOT_SF: vector_of = VEC_SF;
            default: vector_of = VEC_IRQ_BASE + {26'h0, irq_idx, 2'h0};
        endcase
    endfunction
endpackage

// [common/exc_slot_if.sv]
// Pending and active state of every exception slot, with its set and clear strobes
`timescale 1ns/1ps
interface exc_slot_if;
    logic [exc_pkg::NUM_SLOT-1:0] pend_set;
    logic [exc_pkg::NUM_SLOT-1:0] pend_clr;
    logic [exc_pkg::NUM_SLOT-1:0] act_set;
    logic [exc_pkg::NUM_SLOT-1:0] act_clr;
    logic [exc_pkg::NUM_SLOT-1:0] pending;
    logic [exc_pkg::NUM_SLOT-1:0] active;

    modport store (input pend_set, input pend_clr, input act_set, input act_clr, output pending, output active);
    modport ctrl (output pend_set, output pend_clr, output act_set, output act_clr, input pending, input active);
    modport view (input pending, input active);
endinterface

// [rtl/exc_arbiter.sv]
// Picks the most urgent enabled pending slot and the current execution priority
`timescale 1ns/1ps
module exc_arbiter (
    input wire logic route,
    input wire logic [exc_pkg::CFG_W-1:0] prio_cfg,
    input wire logic [exc_pkg::NUM_SLOT-1:0] en_mask,
    exc_slot_if.view slots,
    output logic win_valid,
    output logic [exc_pkg::SLOT_W-1:0] win_slot,
    output logic signed [exc_pkg::PRIO_W-1:0] win_prio,
    output logic signed [exc_pkg::PRIO_W-1:0] cur_prio
);
    import exc_pkg::*;

    // Scan downward so equal priorities go to the lower slot number
    always_comb begin
        logic signed [PRIO_W-1:0] p;
        p = PRIO_THREAD;
        win_valid = 1'b0;
        win_slot = '0;
        win_prio = PRIO_THREAD;
        cur_prio = PRIO_THREAD;
        for (int i = NUM_SLOT - 1; i >= 0; i--) begin
            p = slot_prio(i[SLOT_W-1:0], route, prio_cfg);
            if (slots.pending[i] && en_mask[i] && (!win_valid || p <= win_prio)) begin
                win_valid = 1'b1;
                win_slot = i[SLOT_W-1:0];
                win_prio = p;
            end
            if (slots.active[i] && p < cur_prio) begin
                cur_prio = p;
            end
        end
    end
endmodule // exc_arbiter

// [rtl/exc_slot_table.sv]
// Pending and active flops for every exception slot
`timescale 1ns/1ps
module exc_slot_table (
    input wire logic mclk,
    input wire logic rstn,
    exc_slot_if.store slots
);
    // Set beats clear, so a request landing on the entry cycle stays pending
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            slots.pending <= '0;
            slots.active <= '0;
        end else begin
            slots.pending <= (slots.pending & ~slots.pend_clr) | slots.pend_set;
            slots.active <= (slots.active & ~slots.act_clr) | slots.act_set;
        end
    end
endmodule // exc_slot_table

// [rtl/exception_state_and_fault_routing.sv]
// Exception state tracking, reset restart and fault routing between security states
`timescale 1ns/1ps

// Notes on behaviour
// - Each slot inactive, pending, active, or both
// - Peripheral or software request sets pending
// - Nested handlers leave both slots active
// - Repeat request while active gives active-pending
// - Reset halts the core at once
// - Restart from reset vector, Secure, privileged, Thread
// - Non-maskable interrupt always enabled, priority -2
// - Only reset or Secure top fault preempts it
// - Routing bit picks non-maskable interrupt security
// - Escalated fault priority -1, above configurable ones
// - Bit 0: all escalations go Secure
// - Bit 1: Non-secure escalations stay Non-secure
// - Bit 1: Secure escalated fault at -3
// - Protection violations and execute-never fetches, banked
// - Bus errors raise the bus error fault
// - Bus error fault follows routing bit
// - Usage fault for undefined, unaligned, state, return
// - Unaligned and divide-by-zero only when enabled
// - Interrupt n vector at 0x40 plus 4n
// - Security violation fault always Secure
module exception_state_and_fault_routing (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic fault_nmi_nonsecure_route,
    input wire logic [exc_pkg::NUM_IRQ-1:0] irq_req,
    input wire logic [exc_pkg::NUM_IRQ-1:0] irq_target_ns,
    input wire logic nmi_req,
    input wire logic sw_pend_valid,
    input wire logic [exc_pkg::SLOT_W-1:0] sw_pend_slot,
    input wire logic [exc_pkg::CFG_W-1:0] prio_cfg,
    input wire logic [exc_pkg::NUM_SLOT-1:0] cfg_enable,
    input wire logic cur_secure,
    input wire logic mpu_violation,
    input wire logic xn_fetch_abort,
    input wire logic bus_error,
    input wire logic undef_instr,
    input wire logic unaligned_illegal,
    input wire logic invalid_state,
    input wire logic exc_return_err,
    input wire logic unaligned_hit,
    input wire logic unaligned_trap_en,
    input wire logic div_zero_hit,
    input wire logic div_zero_trap_en,
    input wire logic secure_violation,
    input wire logic entry_ack,
    input wire logic return_valid,
    input wire logic [exc_pkg::SLOT_W-1:0] return_slot,
    output logic core_halt,
    output logic boot_fetch,
    output logic [31:0] boot_vector,
    output logic boot_secure,
    output logic boot_privileged,
    output logic thread_mode,
    output logic entry_valid,
    output logic [exc_pkg::SLOT_W-1:0] entry_slot,
    output logic [31:0] entry_vector,
    output logic entry_secure,
    output logic signed [exc_pkg::PRIO_W-1:0] cur_prio,
    output logic [exc_pkg::NUM_SLOT-1:0] exc_pending,
    output logic [exc_pkg::NUM_SLOT-1:0] exc_active
);
    import exc_pkg::*;

    typedef enum logic [1:0] {BOOT_HOLD, BOOT_FETCH, BOOT_RUN} boot_t;

    boot_t boot_state;
    boot_t next_boot_state;

    exc_slot_if slots();

    wire route;
    wire [NUM_SLOT-1:0] en_mask;
    wire win_valid;
    wire [SLOT_W-1:0] win_slot;
    wire signed [PRIO_W-1:0] win_prio;
    wire signed [PRIO_W-1:0] cur_prio_w;
    wire taking;
    wire running;
    wire mm_req;
    wire uf_req;
    wire [NUM_SLOT-1:0] fault_req;
    wire [NUM_SLOT-1:0] irq_bits;
    wire [NUM_SLOT-1:0] sw_bits;
    wire [NUM_SLOT-1:0] nmi_bits;
    wire [NUM_SLOT-1:0] take_bits;
    wire [NUM_SLOT-1:0] ret_bits;
    logic [NUM_SLOT-1:0] direct_bits;
    logic esc_secure;
    logic esc_nonsecure;
    logic [NUM_SLOT-1:0] esc_bits;
    logic next_entry_valid;

    // One-hot of a slot index, shared by the strobe decoders
    function automatic logic [NUM_SLOT-1:0] onehot(input logic [SLOT_W-1:0] s);
        onehot = '0;
        onehot[s] = 1'b1;
    endfunction

    // Slot state storage and the winner search
    exc_slot_table u_table (
        .mclk(mclk),
        .rstn(rstn),
        .slots(slots)
    );

    exc_arbiter u_arbiter (
        .route(route),
        .prio_cfg(prio_cfg),
        .en_mask(en_mask),
        .slots(slots),
        .win_valid(win_valid),
        .win_slot(win_slot),
        .win_prio(win_prio),
        .cur_prio(cur_prio_w)
    );

    // Routing bit and enables; fixed-priority slots ignore software enables
    assign route = fault_nmi_nonsecure_route;
    assign en_mask = cfg_enable | FIXED_EN_MASK;
    assign running = (boot_state == BOOT_RUN);

    // Reset stops the core in the same cycle, not at an instruction boundary
    assign core_halt = !rstn || !running;

    // Fault causes gathered per exception kind
    assign mm_req = mpu_violation | xn_fetch_abort;
    assign uf_req = undef_instr | unaligned_illegal | invalid_state | exc_return_err
        | (unaligned_hit & unaligned_trap_en) | (div_zero_hit & div_zero_trap_en);

    // Banked faults land in the bank of the current security state
    assign fault_req[SLOT_NMI] = 1'b0;
    assign fault_req[SLOT_HF_S] = 1'b0;
    assign fault_req[SLOT_HF_NS] = 1'b0;
    assign fault_req[SLOT_MM_S] = mm_req & cur_secure;
    assign fault_req[SLOT_MM_NS] = mm_req & ~cur_secure;
    assign fault_req[SLOT_BF] = bus_error;
    assign fault_req[SLOT_UF_S] = uf_req & cur_secure;
    assign fault_req[SLOT_UF_NS] = uf_req & ~cur_secure;
    assign fault_req[SLOT_SF] = secure_violation;
    assign fault_req[NUM_SLOT-1:SLOT_IRQ0] = '0;

    // Asynchronous request sources
    assign irq_bits = {irq_req, {SLOT_IRQ0{1'b0}}};
    assign sw_bits = sw_pend_valid ? onehot(sw_pend_slot) : '0;
    assign nmi_bits = nmi_req ? onehot(SLOT_NMI) : '0;

    // A fault that is disabled or cannot preempt escalates instead.
    // With the routing bit set, the target depends on where the fault was headed; clear, it is Secure.
    always_comb begin
        direct_bits = '0;
        esc_secure = 1'b0;
        esc_nonsecure = 1'b0;
        for (int i = 0; i < NUM_SLOT; i++) begin
            if (fault_req[i]) begin
                if (en_mask[i] && slot_prio(i[SLOT_W-1:0], route, prio_cfg) < cur_prio_w) begin
                    direct_bits[i] = 1'b1;
                end else if (!route || slot_secure(i[SLOT_W-1:0], route, irq_target_ns)) begin
                    esc_secure = 1'b1;
                end else begin
                    esc_nonsecure = 1'b1;
                end
            end
        end
        esc_bits = '0;
        esc_bits[SLOT_HF_S] = esc_secure;
        esc_bits[SLOT_HF_NS] = esc_nonsecure;
    end

    // Entry and return strobes; only an active slot can be returned from
    assign taking = entry_valid & entry_ack;
    assign take_bits = taking ? onehot(entry_slot) : '0;
    assign ret_bits = (return_valid && slots.active[return_slot]) ? onehot(return_slot) : '0;

    // A request while active sets pending on top of active
    assign slots.pend_set = irq_bits | sw_bits | nmi_bits | direct_bits | esc_bits;
    assign slots.pend_clr = take_bits;
    assign slots.act_set = take_bits;
    assign slots.act_clr = ret_bits;

    // The pair {active, pending} per slot is its four-way state
    assign exc_pending = slots.pending;
    assign exc_active = slots.active;
    assign thread_mode = ~|slots.active;

    // Offer an entry only when the winner outranks what is running.
    // The non-maskable interrupt at -2 is beaten only by the -3 level.
    always_comb begin
        next_entry_valid = running && win_valid && (win_prio < cur_prio_w) && !taking;
    end

    // Registered entry offer; a one-cycle gap follows each acceptance
    // so the offer never shows a slot that was just taken.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            entry_valid <= 1'b0;
            entry_slot <= '0;
            entry_vector <= '0;
            entry_secure <= 1'b1;
            cur_prio <= PRIO_THREAD;
        end else begin
            entry_valid <= next_entry_valid;
            entry_slot <= win_slot;
            entry_vector <= vector_of(win_slot);
            entry_secure <= slot_secure(win_slot, route, irq_target_ns);
            cur_prio <= cur_prio_w;
        end
    end

    // Restart sequence after reset release
    always_comb begin
        case (boot_state)
            BOOT_HOLD: next_boot_state = BOOT_FETCH;
            BOOT_FETCH: next_boot_state = BOOT_RUN;
            BOOT_RUN: next_boot_state = BOOT_RUN;
            default: next_boot_state = BOOT_HOLD;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            boot_state <= BOOT_HOLD;
        end else begin
            boot_state <= next_boot_state;
        end
    end

    // Restart always Secure and privileged; reset has no bank
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            boot_fetch <= 1'b0;
            boot_vector <= VEC_RESET;
            boot_secure <= 1'b1;
            boot_privileged <= 1'b1;
        end else begin
            boot_fetch <= (next_boot_state == BOOT_FETCH);
            boot_vector <= VEC_RESET;
            boot_secure <= 1'b1;
            boot_privileged <= 1'b1;
        end
    end
endmodule // exception_state_and_fault_routing

// [test/exc_monitor.sv]
// Assertion checker for the exception state block, bound to its top module
`timescale 1ns/1ps
module exc_monitor (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic fault_nmi_nonsecure_route,
    input wire logic [exc_pkg::NUM_IRQ-1:0] irq_req,
    input wire logic nmi_req,
    input wire logic entry_ack,
    input wire logic core_halt,
    input wire logic boot_fetch,
    input wire logic [31:0] boot_vector,
    input wire logic boot_secure,
    input wire logic boot_privileged,
    input wire logic entry_valid,
    input wire logic [exc_pkg::SLOT_W-1:0] entry_slot,
    input wire logic [31:0] entry_vector,
    input wire logic entry_secure,
    input wire logic signed [exc_pkg::PRIO_W-1:0] cur_prio,
    input wire logic [exc_pkg::NUM_SLOT-1:0] exc_pending,
    input wire logic [exc_pkg::NUM_SLOT-1:0] exc_active
);
    import exc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    // Restart is one fetch cycle from the reset vector, then the core runs
    sequence boot_fetch_s;
        boot_fetch && boot_vector == VEC_RESET && boot_secure && boot_privileged;
    endsequence
    sequence boot_run_s;
        !boot_fetch && !core_halt;
    endsequence

    // Halt must not wait for reset to be sampled, so no disable here
    halt_in_reset_a: assert property (disable iff (1'h0) !rstn |-> core_halt)
        else $error("core not halted in reset");
    boot_order_a: assert property ($rose(rstn) |=> boot_fetch_s ##1 boot_run_s)
        else $error("restart sequence wrong");
    nmi_pend_a: assert property (nmi_req |=> exc_pending[SLOT_NMI])
        else $error("nmi request not pended");
    irq_pend_a: assert property (irq_req[3] |=> exc_pending[12])
        else $error("interrupt request not pended");
    entry_take_a: assert property (entry_valid && entry_ack |=> !entry_valid && exc_active[$past(entry_slot)])
        else $error("entry did not set active");
    nmi_route_a: assert property (entry_valid && entry_slot == SLOT_NMI |->
        entry_vector == VEC_NMI && entry_secure == !$past(fault_nmi_nonsecure_route)) else $error("nmi routing wrong");
    irq_vector_a: assert property (entry_valid && entry_slot >= SLOT_IRQ0 |->
        entry_vector == VEC_IRQ_BASE + {26'h0, entry_slot - SLOT_IRQ0, 2'h0}) else $error("interrupt vector wrong");
    sf_secure_a: assert property (entry_valid && entry_slot == SLOT_SF |-> entry_secure)
        else $error("security violation handler not secure");
    bus_route_a: assert property (entry_valid && entry_slot == SLOT_BF |-> entry_secure != $past(fault_nmi_nonsecure_route))
        else $error("bus fault target wrong");
    hf_secure_a: assert property (entry_valid && entry_slot == SLOT_HF_S |-> entry_secure && entry_vector == VEC_HF)
        else $error("secure escalation not secure");
    nmi_prio_a: assert property (entry_valid && entry_ack && entry_slot == SLOT_NMI |-> ##2 cur_prio == PRIO_NMI)
        else $error("nmi priority wrong");
    nmi_hold_a: assert property (entry_valid && exc_active[SLOT_NMI] && $past(exc_active[SLOT_NMI]) |->
        entry_slot == SLOT_HF_S) else $error("nmi preempted by other exception");
endmodule // exc_monitor

bind exception_state_and_fault_routing exc_monitor i_mon (.*);

// [test/exc_req_src.sv]
// Request sources: peripheral interrupt lines, non-maskable line and software pend
`timescale 1ns/1ps
module exc_req_src (
    input wire logic mclk,
    output logic [exc_pkg::NUM_IRQ-1:0] irq_req,
    output logic nmi_req,
    output logic sw_pend_valid,
    output logic [exc_pkg::SLOT_W-1:0] sw_pend_slot
);
    import exc_pkg::*;
    // Idle at time zero
    initial begin
        irq_req = 7'h00;
        nmi_req = 1'h0;
        sw_pend_valid = 1'h0;
        sw_pend_slot = 4'h0;
    end

    // One-cycle request: 0..6 a peripheral line, 7 the non-maskable line, 16 and up software pend of n-16
    task automatic req(input int n);
        @(posedge mclk) begin
            if (n < 7) begin
                irq_req[n] <= 1'h1;
            end else if (n == 7) begin
                nmi_req <= 1'h1;
            end else begin
                sw_pend_valid <= 1'h1;
                sw_pend_slot <= 4'(n - 16);
            end
        end
        @(posedge mclk) begin
            irq_req <= 7'h00;
            nmi_req <= 1'h0;
            sw_pend_valid <= 1'h0;
        end
        #1;
    endtask
endmodule // exc_req_src

// [test/tb_exception_state_and_fault_routing.sv]
// Self-checking bench for the exception state and fault routing block
`timescale 1ns/1ps
module tb_exception_state_and_fault_routing;
    import exc_pkg::*;
    logic mclk = 1'h0;
    logic rstn = 1'h0;
    logic fault_nmi_nonsecure_route = 1'h0;
    logic nmi_req, sw_pend_valid, cur_secure, unaligned_trap_en, div_zero_trap_en, entry_ack, return_valid;
    logic core_halt, boot_fetch, boot_secure, boot_privileged, thread_mode, entry_valid, entry_secure;
    logic [NUM_IRQ-1:0] irq_req, irq_target_ns;
    logic [31:0] boot_vector, entry_vector;
    logic [SLOT_W-1:0] sw_pend_slot, entry_slot, return_slot;
    logic signed [PRIO_W-1:0] cur_prio;
    logic [NUM_SLOT-1:0] cfg_enable, exc_pending, exc_active;
    logic [CFG_W-1:0] prio_cfg;
    logic [9:0] fc;
    int n_errors = 0;
    int samples_checked = 0;
    // Fault cause bit k raises the handler slot and vector of row k
    int slot_of [10] = '{3, 3, 5, 6, 6, 6, 8, 6, 6, 6};
    logic [31:0] vec_of [10] = '{32'h10, 32'h10, 32'h14, 32'h18, 32'h18, 32'h18, 32'h1c, 32'h18, 32'h18, 32'h18};

    exc_req_src i_src (.*);
    exception_state_and_fault_routing i_dut (.*, .mpu_violation(fc[0]), .xn_fetch_abort(fc[1]), .bus_error(fc[2]),
        .undef_instr(fc[3]), .unaligned_hit(fc[4]), .div_zero_hit(fc[5]), .secure_violation(fc[6]),
        .unaligned_illegal(fc[7]), .invalid_state(fc[8]), .exc_return_err(fc[9]));

    always #10 mclk = ~mclk;

    task final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Wait for an offer, check it, acknowledge; the offer holds until taken, so ack goes up a cycle late
    task take(input logic [3:0] s, input logic [31:0] v, input logic sec);
        int n;
        n = 0;
        while (entry_valid !== 1'h1 && n < 20) begin
            @(posedge mclk);
            #1 n++;
        end
        chk({entry_valid, entry_slot, entry_secure}, {1'h1, s, sec});
        chk(entry_vector, v);
        @(posedge mclk) entry_ack <= 1'h1;
        @(posedge mclk) entry_ack <= 1'h0;
        #1 chk({exc_active[s], exc_pending[s]}, 2'h2);
    endtask

    task ret(input logic [3:0] s);
        @(posedge mclk) begin
            return_valid <= 1'h1;
            return_slot <= s;
        end
        @(posedge mclk) return_valid <= 1'h0;
        #1 chk(exc_active[s], 1'h0);
    endtask

    task fault(input int k);
        @(posedge mclk) fc[k] <= 1'h1;
        @(posedge mclk) fc <= 10'h000;
        #1;
    endtask

    // Reset for n+1 cycles, then check the restart sequence
    task boot(input int n);
        @(posedge mclk) rstn <= 1'h0;
        #1 chk(core_halt, 1'h1);
        repeat (n) @(posedge mclk);
        #1 chk(exc_active, 16'h0000);
        @(posedge mclk) rstn <= 1'h1;
        @(posedge mclk);
        #1 chk({boot_fetch, boot_secure, boot_privileged, thread_mode}, 4'hf);
        chk(boot_vector, VEC_RESET);
        @(posedge mclk);
        #1 chk({boot_fetch, core_halt}, 2'h0);
        $display("test boot done");
    endtask

    // Pend, re-pend while active, nesting under the non-maskable interrupt, software pend
    task t_irq();
        i_src.req(3);
        chk(exc_pending[12], 1'h1);
        take(4'hc, 32'h4c, 1'h1);
        i_src.req(3);
        chk({exc_active[12], exc_pending[12]}, 2'h3);
        i_src.req(7);
        take(SLOT_NMI, VEC_NMI, 1'h1);
        chk(exc_active[12], 1'h1);
        repeat (3) @(posedge mclk);
        #1 chk(cur_prio, PRIO_NMI);
        chk(entry_valid, 1'h0);
        ret(SLOT_NMI);
        ret(4'hc);
        take(4'hc, 32'h4c, 1'h1);
        ret(4'hc);
        @(posedge mclk) irq_target_ns <= 7'h40;
        i_src.req(31);
        take(4'hf, 32'h58, 1'h0);
        ret(4'hf);
        chk(thread_mode, 1'h1);
        $display("test irq done");
    endtask

    // A raised configurable priority beats a lower slot number; the loser waits pending
    task t_prio();
        @(posedge mclk) prio_cfg[3*14 +: 3] <= 3'h1;
        i_src.req(0);
        i_src.req(5);
        @(posedge mclk);
        #1;
        take(4'he, 32'h54, 1'h1);
        repeat (2) @(posedge mclk);
        #1 chk({entry_valid, exc_pending[9]}, 2'h1);
        ret(4'he);
        take(4'h9, 32'h40, 1'h1);
        ret(4'h9);
        @(posedge mclk) prio_cfg[3*14 +: 3] <= 3'h4;
        $display("test prio done");
    endtask

    // Escalation under both routing settings, with every fault handler disabled
    task t_route();
        fault(2);
        chk(exc_pending[SLOT_HF_S], 1'h1);
        take(SLOT_HF_S, VEC_HF, 1'h1);
        ret(SLOT_HF_S);
        @(posedge mclk) begin
            fault_nmi_nonsecure_route <= 1'h1;
            cur_secure <= 1'h0;
        end
        fault(0);
        take(SLOT_HF_NS, VEC_HF, 1'h0);
        ret(SLOT_HF_NS);
        i_src.req(7);
        take(SLOT_NMI, VEC_NMI, 1'h0);
        fault(6);
        take(SLOT_HF_S, VEC_HF, 1'h1);
        @(posedge mclk);
        #1 chk(cur_prio, PRIO_HF_SEC_TOP);
        ret(SLOT_HF_S);
        ret(SLOT_NMI);
        $display("test route done");
    endtask

    // Every fault cause with its handler enabled, a Non-secure bank, then the untrapped cases
    task t_direct();
        @(posedge mclk) begin
            cfg_enable <= 16'hfff8;
            cur_secure <= 1'h1;
            unaligned_trap_en <= 1'h1;
            div_zero_trap_en <= 1'h1;
        end
        for (int k = 0; k < 10; k++) begin
            fault(k);
            take(4'(slot_of[k]), vec_of[k], k != 2);
            ret(4'(slot_of[k]));
        end
        @(posedge mclk) cur_secure <= 1'h0;
        fault(1);
        take(SLOT_MM_NS, VEC_MM, 1'h0);
        ret(SLOT_MM_NS);
        @(posedge mclk) begin
            unaligned_trap_en <= 1'h0;
            div_zero_trap_en <= 1'h0;
        end
        fault(4);
        fault(5);
        chk(exc_pending, 16'h0000);
        $display("test direct done");
    endtask

    // Main sequence; every slot priority field is 4, above the thread level
    initial begin
        {entry_ack, return_valid, cur_secure, unaligned_trap_en, div_zero_trap_en} = 5'h00;
        return_slot = 4'h0;
        irq_target_ns = 7'h00;
        fc = 10'h000;
        prio_cfg = 48'h924924924924;
        cfg_enable = 16'hfe00;
        boot(20);
        t_irq();
        t_prio();
        t_route();
        t_direct();
        i_src.req(7);
        take(SLOT_NMI, VEC_NMI, 1'h0);
        boot(2);
        final_report();
    end

    // Cut a hang short; the run needs well under two thousand cycles
    initial begin
        #100000;
        n_errors++;
        final_report();
    end
endmodule // tb_exception_state_and_fault_routing
